/* design/tmc_params.svh */
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// Register indices as printed; byte address is four times the index
`define TMC_IDX_CTRL 32'h4004_4000
`define TMC_IDX_IOCTL 32'h4004_4001
`define TMC_IDX_MODE 32'h4004_4002
`define TMC_IDX_GATE 32'h4004_4003

// Reset values
`define TMC_RST_CTRL 8'h00
`define TMC_RST_IOCTL 8'h00
`define TMC_RST_MODE 8'h00
`define TMC_RST_GATE 8'h00

// Writable bit masks; other bits are reserved
`define TMC_MASK_IOCTL 8'hf5
`define TMC_MASK_MODE 8'h7f
`define TMC_MASK_GATE 8'h07

// I/O control fields
`define TMC_IOC_POL 0
`define TMC_IOC_OE 2
`define TMC_IOC_FLT_LO 4
`define TMC_IOC_EGT_LO 6

// Mode select fields
`define TMC_MR_MODE_LO 0
`define TMC_MR_EDGE 3
`define TMC_MR_SRC_LO 4

// Event gate select fields
`define TMC_GS_TMR_LO 0
`define TMC_GS_LVL 2

// Control/status fields
`define TMC_CR_RUN 0
`define TMC_CR_ACT 1

// Divider terminal counts
`define TMC_DIV8_LAST 3'h7
`define TMC_DIV32_LAST 5'h1f

// Synchroniser lanes
`define TMC_SYNC_W 8

`endif

/* design/tmc_pkg.sv */
package tmc_pkg;

  // Operating mode codes
  typedef enum logic [2:0] {
    TMC_MODE_TIMER = 3'h0,
    TMC_MODE_PULSE_OUT = 3'h1,
    TMC_MODE_EVENT = 3'h2,
    TMC_MODE_WIDTH = 3'h3,
    TMC_MODE_PERIOD = 3'h4
  } tmc_mode_e;

  // Count source codes
  typedef enum logic [2:0] {
    TMC_SRC_FCLK = 3'h0,
    TMC_SRC_DIV8 = 3'h1,
    TMC_SRC_DIV2 = 3'h3,
    TMC_SRC_LOSC = 3'h4,
    TMC_SRC_ELINK = 3'h5,
    TMC_SRC_SUB = 3'h6
  } tmc_src_e;

  // Event gate codes
  typedef enum logic [1:0] {
    TMC_EGT_ALWAYS = 2'h0,
    TMC_EGT_IRQ4 = 2'h1,
    TMC_EGT_TIMER = 2'h2
  } tmc_egt_e;

  // Input filter codes
  typedef enum logic [1:0] {
    TMC_FLT_NONE = 2'h0,
    TMC_FLT_FCLK = 2'h1,
    TMC_FLT_DIV8 = 2'h2,
    TMC_FLT_DIV32 = 2'h3
  } tmc_flt_e;

  // Synchroniser state
  typedef struct packed {
    logic [7:0] ff1;
    logic [7:0] ff2;
    logic [7:0] ff3;
    logic [7:0] stable;
  } tmc_sync_s;

  // Main block state
  typedef struct packed {
    logic [7:0] ioctl;
    logic [7:0] mode;
    logic [7:0] gate;
    logic run;
    logic active;
    logic [2:0] div8;
    logic div2;
    logic [4:0] fprescale;
    logic [1:0] fhist;
    logic io_filt;
    logic io_filt_d;
    logic losc_d;
    logic sub_d;
    logic io_out;
    logic tout;
    logic tick;
    logic win;
    logic edge_ev;
    logic reinit;
    logic [31:0] prdata;
    logic slverr;
  } tmc_state_s;

endpackage

/* design/tmc_sync.sv */
`timescale 1ns/1ns
`include "tmc_params.svh"

// Three-stage synchroniser; a change counts once stages two and three agree
module tmc_sync
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`TMC_SYNC_W-1:0] async_in,
  output logic [`TMC_SYNC_W-1:0] sync_out
);

  tmc_sync_s s_reg; // Registered state
  tmc_sync_s s_next; // Next state

  ////////////////////////////////////////////////////////////////////////
  // Next state: only ff2 reads ff1, keeping metastability contained
  always_comb begin
    s_next = s_reg;
    s_next.ff1 = async_in;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    // Per lane: take the new level once two late stages agree
    for (int i = 0; i < `TMC_SYNC_W; i++) begin
      if (s_reg.ff2[i] == s_reg.ff3[i]) begin
        s_next.stable[i] = s_reg.ff3[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stable;

endmodule // tmc_sync

/* design/tmc_timer_cfg.sv */
`timescale 1ns/1ns
`include "tmc_params.svh"

module tmc_timer_cfg
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_io_pin_in,
  output logic timer_io_pin_out,
  output logic timer_io_pin_oe_n,
  output logic timer_out_pin,
  output logic timer_out_pin_oe_n,
  input wire logic ext_irq4_input,
  input wire logic gate_src_a,
  input wire logic gate_src_b,
  input wire logic gate_src_c,
  input wire logic gate_src_d,
  input wire logic low_speed_osc_clock,
  input wire logic subsys_clock,
  input wire logic event_link_event,
  input wire logic underflow_pulse,
  output logic count_tick,
  output logic count_active_flag,
  output logic measure_window,
  output logic measure_edge,
  output logic mode_reinit
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Word-index match on the low ten index bits
  function automatic logic idx_hit(input logic [31:0] addr,
                                   input logic [31:0] idx);
    idx_hit = (addr[11:2] == idx[9:0]);
  endfunction

  // Rising edge between previous and current level
  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  tmc_state_s s_reg; // Registered state
  tmc_state_s s_next; // Next state
  logic [7:0] sync_v; // Raw pin levels into the synchroniser
  logic io_s; // Synchronised io pin
  logic irq4_s; // Synchronised irq4 input
  logic [3:0] gsrc_s; // Synchronised gate timers
  logic losc_s; // Synchronised low-speed oscillator
  logic sub_s; // Synchronised subsystem clock
  tmc_mode_e mode; // Decoded mode field
  tmc_src_e src; // Decoded source field
  tmc_flt_e flt; // Decoded filter field
  tmc_egt_e egt; // Decoded gate field
  logic pol; // Polarity bit
  logic both; // Both-edge bit
  logic glvl; // Gate level bit
  logic [1:0] gtmr; // Gate timer field
  logic samp_en; // Filter sample strobe
  logic src_tick; // Internal source tick
  logic ev_edge; // Counted io edge
  logic gate_ok; // Event gate open
  logic acc; // APB access phase
  logic wr; // Write takes effect
  logic hit_any; // Address maps to a register

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; slow clocks treated as sampled levels
  tmc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(sync_v),
    .sync_out({sub_s, losc_s, gsrc_s, irq4_s, io_s})
  );

  assign sync_v = {subsys_clock, low_speed_osc_clock, gate_src_d,
                   gate_src_c, gate_src_b, gate_src_a, ext_irq4_input,
                   timer_io_pin_in};

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  assign mode = tmc_mode_e'(s_reg.mode[`TMC_MR_MODE_LO +: 3]);
  assign src = tmc_src_e'(s_reg.mode[`TMC_MR_SRC_LO +: 3]);
  assign flt = tmc_flt_e'(s_reg.ioctl[`TMC_IOC_FLT_LO +: 2]);
  assign egt = tmc_egt_e'(s_reg.ioctl[`TMC_IOC_EGT_LO +: 2]);
  assign pol = s_reg.ioctl[`TMC_IOC_POL];
  assign both = s_reg.mode[`TMC_MR_EDGE];
  assign glvl = s_reg.gate[`TMC_GS_LVL];
  assign gtmr = s_reg.gate[`TMC_GS_TMR_LO +: 2];

  // APB phase decode
  assign acc = psel & penable;
  assign wr = acc & pwrite & pstrb[0];
  assign hit_any = idx_hit(paddr, `TMC_IDX_CTRL)
                 | idx_hit(paddr, `TMC_IDX_IOCTL)
                 | idx_hit(paddr, `TMC_IDX_MODE)
                 | idx_hit(paddr, `TMC_IDX_GATE);

  ////////////////////////////////////////////////////////////////////////
  // Filter sample strobe from a free prescaler
  always_comb begin
    case (flt)
      TMC_FLT_FCLK: samp_en = 1'b1;
      TMC_FLT_DIV8: samp_en = (s_reg.fprescale[2:0] == `TMC_DIV8_LAST);
      TMC_FLT_DIV32: samp_en = (s_reg.fprescale == `TMC_DIV32_LAST);
      default: samp_en = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Internal count source; prohibited codes give no tick
  always_comb begin
    case (src)
      TMC_SRC_FCLK: src_tick = 1'b1;
      TMC_SRC_DIV8: src_tick = (s_reg.div8 == `TMC_DIV8_LAST);
      TMC_SRC_DIV2: src_tick = s_reg.div2;
      TMC_SRC_LOSC: src_tick = rose(losc_s, s_reg.losc_d);
      TMC_SRC_ELINK: src_tick = event_link_event;
      TMC_SRC_SUB: src_tick = rose(sub_s, s_reg.sub_d);
      default: src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Event edge on the filtered io level
  always_comb begin
    if (both) begin
      ev_edge = s_reg.io_filt ^ s_reg.io_filt_d;
    end else if (pol) begin
      ev_edge = rose(s_reg.io_filt_d, s_reg.io_filt);
    end else begin
      ev_edge = rose(s_reg.io_filt, s_reg.io_filt_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Event gate; code 11 is prohibited and keeps the gate shut
  always_comb begin
    case (egt)
      TMC_EGT_ALWAYS: gate_ok = 1'b1;
      TMC_EGT_IRQ4: gate_ok = (irq4_s == glvl);
      TMC_EGT_TIMER: gate_ok = (gsrc_s[gtmr] == glvl);
      default: gate_ok = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic tick_src; // Tick of the source in use
    tick_src = 1'b0;
    s_next = s_reg;

    // Dividers and edge history
    s_next.div8 = s_reg.div8 + 3'h1;
    s_next.div2 = ~s_reg.div2;
    s_next.fprescale = s_reg.fprescale + 5'h01;
    s_next.losc_d = losc_s;
    s_next.sub_d = sub_s;
    s_next.io_filt_d = s_reg.io_filt;

    // Input filter: three equal samples before a new level is taken
    if (flt == TMC_FLT_NONE) begin
      s_next.io_filt = io_s;
      s_next.fhist = {io_s, io_s};
    end else if (samp_en) begin
      s_next.fhist = {s_reg.fhist[0], io_s};
      if (io_s == s_reg.fhist[0] && io_s == s_reg.fhist[1]) begin
        s_next.io_filt = io_s;
      end
    end

    // Event mode counts the io pin regardless of source field
    if (mode == TMC_MODE_EVENT) begin
      tick_src = ev_edge & gate_ok;
    end else begin
      tick_src = src_tick;
    end

    // Active flag catches up with run on a source tick
    if (tick_src) begin
      s_next.active = s_reg.run;
    end
    s_next.tick = tick_src & s_reg.active;

    // Measurement helpers for the counter datapath
    s_next.win = (mode == TMC_MODE_WIDTH) & (s_reg.io_filt == pol);
    s_next.edge_ev = 1'b0;
    if (mode == TMC_MODE_PERIOD) begin
      if (pol) begin
        s_next.edge_ev = rose(s_reg.io_filt_d, s_reg.io_filt);
      end else begin
        s_next.edge_ev = rose(s_reg.io_filt, s_reg.io_filt_d);
      end
    end

    // Pin outputs toggle on underflow while counting
    if (underflow_pulse && s_reg.active) begin
      s_next.tout = ~s_reg.tout;
      s_next.io_out = ~s_reg.io_out;
    end

    // APB read data, captured in the setup cycle
    s_next.reinit = 1'b0;
    if (psel && !penable) begin
      s_next.prdata = 32'h0000_0000;
      s_next.slverr = ~hit_any;
      if (idx_hit(paddr, `TMC_IDX_CTRL)) begin
        s_next.prdata[`TMC_CR_RUN] = s_reg.run;
        s_next.prdata[`TMC_CR_ACT] = s_reg.active;
      end else if (idx_hit(paddr, `TMC_IDX_IOCTL)) begin
        s_next.prdata[7:0] = s_reg.ioctl;
      end else if (idx_hit(paddr, `TMC_IDX_MODE)) begin
        s_next.prdata[7:0] = s_reg.mode;
      end else if (idx_hit(paddr, `TMC_IDX_GATE)) begin
        s_next.prdata[7:0] = s_reg.gate;
      end
    end

    // APB writes; reserved bits are masked off
    if (wr) begin
      if (idx_hit(paddr, `TMC_IDX_CTRL)) begin
        s_next.run = pwdata[`TMC_CR_RUN];
      end else if (idx_hit(paddr, `TMC_IDX_IOCTL)) begin
        s_next.ioctl = pwdata[7:0] & `TMC_MASK_IOCTL;
      end else if (idx_hit(paddr, `TMC_IDX_MODE)) begin
        // Source and mode are taken as written; keeping them
        // still while counting is left to software
        s_next.mode = pwdata[7:0] & `TMC_MASK_MODE;
        s_next.reinit = 1'b1;
        // Both pins back to their initial levels
        s_next.tout = s_reg.ioctl[`TMC_IOC_POL];
        s_next.io_out = ~s_reg.ioctl[`TMC_IOC_POL];
      end else if (idx_hit(paddr, `TMC_IDX_GATE)) begin
        s_next.gate = pwdata[7:0] & `TMC_MASK_GATE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; all control state clears on reset, except io_out, which resets high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.ioctl <= `TMC_RST_IOCTL;
      s_reg.mode <= `TMC_RST_MODE;
      s_reg.gate <= `TMC_RST_GATE;
      s_reg.io_out <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero-wait slave; unmapped words answer with an error
  assign pready = 1'b1;
  assign pslverr = s_reg.slverr & acc;
  assign prdata = s_reg.prdata;

  // The io pin is driven only in pulse output mode
  assign timer_io_pin_out = s_reg.io_out;
  assign timer_io_pin_oe_n = ~(mode == TMC_MODE_PULSE_OUT);
  assign timer_out_pin = s_reg.tout;
  assign timer_out_pin_oe_n = ~s_reg.ioctl[`TMC_IOC_OE];

  assign count_tick = s_reg.tick;
  assign count_active_flag = s_reg.active;
  assign measure_window = s_reg.win;
  assign measure_edge = s_reg.edge_ev;
  assign mode_reinit = s_reg.reinit;

endmodule // tmc_timer_cfg

/* bench/tmc_chk_sva.sv */
`timescale 1ns/1ns
module tmc_chk
  import tmc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_io_pin_out,
  input wire logic timer_io_pin_oe_n,
  input wire logic timer_out_pin,
  input wire logic timer_out_pin_oe_n,
  input wire logic underflow_pulse,
  input wire logic count_tick,
  input wire logic count_active_flag,
  input wire logic mode_reinit
);
  // Shadow of what software wrote
  typedef struct packed {
    logic [7:0] ioc;
    logic [2:0] md;
    logic run;
  } tmc_chk_s;
  tmc_chk_s st_reg, st_next;
  logic acc, wr; // Access phase, accepted write
  logic [9:0] ix; // Word index
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  assign ix = paddr[11:2];
  ////////////////////////////////////////////////////////////////////////
  // Next shadow value
  always_comb begin
    st_next = st_reg;
    if (wr && ix == 10'h0) st_next.run = pwdata[0];
    if (wr && ix == 10'h1) st_next.ioc = pwdata[7:0] & 8'hf5;
    if (wr && ix == 10'h2) st_next.md = pwdata[2:0];
  end
  // Shadow register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_reg <= '0;
    else st_reg <= st_next;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Mode write while idle, so no toggle can blur the start level
  sequence s_mwr;
    wr && ix == 10'h2 && !count_active_flag && !underflow_pulse;
  endsequence
  property p_rdy; acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_unm; acc && ix > 10'h3 |-> pslverr && prdata == 32'h0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_rsv; acc && !pwrite && ix == 10'h1 |-> !(|(prdata & 32'hffffff0a));
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
  property p_oe; $stable(st_reg.ioc[2]) |-> timer_out_pin_oe_n == !st_reg.ioc[2];
  endproperty
  a_oe: assert property (p_oe) else $error("out enable wrong");
  property p_iooe; $stable(st_reg.md) |->
    timer_io_pin_oe_n == (st_reg.md != TMC_MODE_PULSE_OUT); endproperty
  a_iooe: assert property (p_iooe) else $error("io enable wrong");
  property p_rein; s_mwr |-> ##[1:2] mode_reinit; endproperty
  a_rein: assert property (p_rein) else $error("no reinit pulse");
  property p_init; s_mwr |-> ##2 timer_out_pin == st_reg.ioc[0] &&
    timer_io_pin_out != st_reg.ioc[0]; endproperty
  a_init: assert property (p_init) else $error("start level wrong");
  property p_tick; count_tick |-> $past(count_active_flag); endproperty
  a_tick: assert property (p_tick) else $error("tick while idle");
  property p_act; $changed(count_active_flag) |->
    count_active_flag == st_reg.run; endproperty
  a_act: assert property (p_act) else $error("active off run");
endmodule // tmc_chk
bind tmc_timer_cfg tmc_chk tmc_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_io_pin_out(timer_io_pin_out),
  .timer_io_pin_oe_n(timer_io_pin_oe_n), .timer_out_pin(timer_out_pin),
  .timer_out_pin_oe_n(timer_out_pin_oe_n),
  .underflow_pulse(underflow_pulse), .count_tick(count_tick),
  .count_active_flag(count_active_flag), .mode_reinit(mode_reinit));

/* bench/tmc_pin_partner.sv */
`timescale 1ns/1ns
// Pulse source on the io pin plus the two free-running slow oscillators
module tmc_pin_partner (
  input wire logic pclk,
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic [7:0] width,
  output logic io_level,
  output logic busy,
  output logic low_osc,
  output logic sub_clk
);
  initial begin
    io_level = 0;
    busy = 0;
    low_osc = 0;
    sub_clk = 0;
  end
  // Oscillators run free, unrelated to pclk
  always #1525 low_osc = ~low_osc;
  always #1235 sub_clk = ~sub_clk;
  // High pulses; long gap lets the slowest filter settle
  always @(posedge pclk) begin
    if (go) begin
      busy <= 1;
      repeat (n) begin
        @(posedge pclk);
        io_level <= 1;
        repeat (width) @(posedge pclk);
        io_level <= 0;
        repeat (200) @(posedge pclk);
      end
      busy <= 0;
    end
  end
endmodule // tmc_pin_partner

/* bench/tb.sv */
`timescale 1ns/1ns
`include "tmc_params.svh"
module tb;
  import tmc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb, gsrc;
  logic io_out, io_oe_n, io_wire, out_pin, out_oe_n, irq4, uflow;
  logic tick, act, go, busy, io_lvl, losc, sclk;
  logic elk, mwin, medg; // Link event, measurement helpers
  logic [7:0] wid;
  int errors, n_checks, cyc, nt, cur, a, ne;
  int mdl[4]; // Register model
  int msk[4] = '{1, 'hf5, 'h7f, 'h07};
  int cio[10] = '{0, 1, 'h10, 'h10, 'h20, 'h40, 'h40, 'h80, 'hc0, 0};
  int cg[10] = '{0, 0, 0, 0, 0, 4, 0, 0, 0, 0};
  int cw[10] = '{4, 4, 2, 6, 16, 4, 4, 4, 4, 4};
  int ce[10] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1};
  logic [31:0] base[4] = '{`TMC_IDX_CTRL << 2, `TMC_IDX_IOCTL << 2,
    `TMC_IDX_MODE << 2, `TMC_IDX_GATE << 2};
  // Pin wire: device drives only while enabled
  assign io_wire = io_oe_n ? io_lvl : io_out;
  tmc_timer_cfg tmc_timer_cfg_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_io_pin_in(io_wire),
    .timer_io_pin_out(io_out), .timer_io_pin_oe_n(io_oe_n),
    .timer_out_pin(out_pin), .timer_out_pin_oe_n(out_oe_n),
    .ext_irq4_input(irq4), .gate_src_a(gsrc[0]), .gate_src_b(gsrc[1]),
    .gate_src_c(gsrc[2]), .gate_src_d(gsrc[3]),
    .low_speed_osc_clock(losc), .subsys_clock(sclk),
    .event_link_event(elk), .underflow_pulse(uflow), .count_tick(tick),
    .count_active_flag(act), .measure_window(mwin), .measure_edge(medg),
    .mode_reinit());
  tmc_pin_partner tmc_pin_partner_i (.pclk(pclk), .go(go), .n(8'h3),
    .width(wid), .io_level(io_lvl), .busy(busy), .low_osc(losc),
    .sub_clk(sclk));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard and tick count, sampled off the launching edge
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      end_sim();
    end
  end
  always @(negedge pclk) if (tick === 1'b1) nt++;
  // Period-mode edge pulses, counted the same way
  always @(negedge pclk) if (medg === 1'b1) ne++;
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; index 5 is unmapped
  task automatic apb(input int i, input logic w, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    pstrb <= s;
    pwdata <= d;
    paddr <= (i < 4) ? base[i] : 32'h14;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input int i, input int d);
    apb(i, 1, d, 4'h1);
    mdl[i] = d & msk[i];
  endtask
  task automatic rdc(input int i, input int x);
    apb(i, 0, 0, 4'h0);
    chk(rd, (i < 4) ? (mdl[i] | x) : 0);
    chk(er, i > 3);
  endtask
  task automatic pulses(input int w);
    wid <= w;
    go <= 1;
    @(posedge pclk);
    go <= 0;
    @(posedge pclk);
    while (busy) @(posedge pclk);
  endtask
  task automatic waitact(input logic v);
    for (int c = 0; c < 3000 && act !== v; c++) @(posedge pclk);
    chk(act, v);
  endtask
  // Stop, then change mode only while idle
  task automatic arm(input int e);
    wr(1, 0);
    wr(0, 0);
    pulses(4);
    waitact(0);
    wr(2, 'h72 | (e << 3));
    wr(0, 1);
    pulses(4);
    waitact(1);
    cur = e;
  endtask
  function automatic int expn(int ioc, int g, int w, int e, int q);
    int f, ok, lv;
    f = (ioc >> 4) & 3;
    lv = (g >> 2) & 1;
    case ((ioc >> 6) & 3)
      0: ok = 1;
      1: ok = (q == lv);
      2: ok = (gsrc[g & 3] == lv);
      default: ok = 0;
    endcase
    if (f != 0 && w <= 3 * (f == 1 ? 1 : (f == 2 ? 8 : 32))) ok = 0;
    return ok ? 3 * (e + 1) : 0;
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, go, irq4, uflow, elk} = '0;
    paddr = 0;
    pwdata = 0;
    pstrb = 0;
    gsrc = 0;
    wid = 4;
    presetn = 0;
    a = $urandom(88803);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    for (int i = 0; i < 6; i++) rdc(i, 0);
    repeat (12) begin
      a = 1 + $urandom % 3;
      wr(a, $urandom);
      rdc(a, 0);
    end
    apb(1, 1, 32'hff, 4'h0);
    rdc(1, 0);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      wr(1, (k[1] << 2) | k[0]);
      wr(2, 1);
      repeat (3) @(posedge pclk);
      chk(out_pin, k[0]);
      chk(io_out, !k[0]);
      chk(out_oe_n, !k[1]);
      chk(io_oe_n, 0);
    end
    wr(0, 1);
    waitact(1);
    rdc(0, 2);
    a = nt;
    repeat (20) @(posedge pclk);
    chk(nt - a, 20);
    uflow <= 1;
    @(posedge pclk);
    uflow <= 0;
    repeat (2) @(posedge pclk);
    chk(out_pin, 1);
    chk(io_out, 0);
    wr(0, 0);
    waitact(0);
    $display("test pins done");
    // Divided, slow and linked sources, each selected while stopped
    wr(2, 'h10);
    wr(0, 1);
    waitact(1);
    a = nt;
    repeat (80) @(posedge pclk);
    chk(nt - a, 10);
    wr(0, 0);
    waitact(0);
    // Oscillator supply is taken as enabled before this choice
    wr(2, 'h40);
    wr(0, 1);
    waitact(1);
    a = nt;
    repeat (700) @(posedge pclk);
    chk(nt - a > 1, 1);
    wr(0, 0);
    waitact(0);
    wr(2, 'h50);
    wr(0, 1);
    a = nt;
    repeat (4) begin
      elk <= 1;
      @(posedge pclk);
      elk <= 0;
      repeat (3) @(posedge pclk);
    end
    chk(nt - a, 3);
    chk(act, 1);
    wr(0, 0);
    elk <= 1;
    @(posedge pclk);
    elk <= 0;
    repeat (3) @(posedge pclk);
    chk(act, 0);
    $display("test sources done");
    arm(0);
    for (int c = 0; c < 10; c++) begin
      if (ce[c] != cur) arm(ce[c]);
      wr(1, cio[c]);
      wr(3, (cio[c] == 'h80) ? $urandom % 8 : cg[c]);
      gsrc <= $urandom;
      repeat (20) @(posedge pclk);
      a = nt;
      pulses(cw[c]);
      repeat (40) @(posedge pclk);
      chk(nt - a, expn(cio[c], mdl[3], cw[c], ce[c], 0));
    end
    $display("test events done");
    // Measurement helpers; stop before switching mode
    wr(1, 0);
    wr(0, 0);
    pulses(4);
    waitact(0);
    wr(2, 'h03);
    repeat (8) @(posedge pclk);
    chk(mwin, 1);
    wr(1, 1);
    repeat (8) @(posedge pclk);
    chk(mwin, 0);
    wr(2, 'h04);
    repeat (8) @(posedge pclk);
    a = ne;
    pulses(4);
    repeat (40) @(posedge pclk);
    chk(ne - a, 3);
    $display("test measure done");
    end_sim();
  end
endmodule // tb
